// [rtl/frt_edge_sync.sv]
// Two-stage pin synchroniser with rise and fall pulses
`timescale 1ns/10ps
`default_nettype none
module frt_edge_sync
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and edge pulses
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic [2:0] fill_r;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Pin idles high or low; no edge until every stage holds a real pin sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fill_r <= '0;
    else
      fill_r <= {fill_r[1:0], 1'b1};
  end

  assign rise_o = fill_r[2] && sync_r && !last_r;
  assign fall_o = fill_r[2] && !sync_r && last_r;
endmodule
`default_nettype wire

// [rtl/frt_pkg.sv]
// Shared constants for the free-running timer core
package frt_pkg;
  // ==========================================================
  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [7:0] IDX_FLAGS = 8'h13;
  localparam logic [7:0] IDX_CAP_HI = 8'h14;
  localparam logic [7:0] IDX_CAP_LO = 8'h15;
  localparam logic [7:0] IDX_CMP_HI = 8'h16;
  localparam logic [7:0] IDX_CMP_LO = 8'h17;
  localparam logic [7:0] IDX_MAIN_HI = 8'h18;
  localparam logic [7:0] IDX_MAIN_LO = 8'h19;
  localparam logic [7:0] IDX_ALT_HI = 8'h1A;
  localparam logic [7:0] IDX_ALT_LO = 8'h1B;
  // ==========================================================
  // Control and flag bit positions
  localparam int CAP_BIT = 7;
  localparam int CMP_BIT = 6;
  localparam int OVF_BIT = 5;
  localparam int EDGE_BIT = 1;
  localparam int LEVEL_BIT = 0;
  localparam logic [7:0] CONTROL_RW_MASK = 8'hE3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // ==========================================================
  // Counter constants
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_LAST = 16'hFFFF;
  localparam int PRESCALE_DIV = 4;
  localparam int STARTUP_DEFAULT = 64;
endpackage

// [rtl/frt_prescaler.sv]
// Fixed divide-by-N prescaler producing one tick per N clocks
`timescale 1ns/10ps
`default_nettype none
module frt_prescaler
  import frt_pkg::*;
#(
  parameter int DIV = PRESCALE_DIV
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control and tick
  input wire logic run_i,
  output logic tick_o
);
  logic [$clog2(DIV)-1:0] div_r;
  localparam logic [$clog2(DIV)-1:0] DIV_LAST = $clog2(DIV)'(DIV - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
      div_r <= '0;
    else
      div_r <= (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
  end

  assign tick_o = run_i && (div_r == DIV_LAST);
endmodule
`default_nettype wire

// [rtl/frt_timer_core.sv]
// Free-running timer core with APB register access
// Functional notes
// - Counter advances once every four bus clocks through a fixed prescaler.
// - Reset loads FFFC into the counter; software can never write it.
// - After reset the counter holds its preset until start-up delay elapses.
// - Increments happen on prescaler ticks only; reads never alter the count.
// - Wrap from FFFF to 0000 sets overflow flag, interrupting if enabled.
// - Counter readable at main pair 18/19 and alternate 1A/1B, high first.
// - Low-byte read without prior high read returns the live count.
// - High read buffers low byte once; next low read returns buffer, ends.
// - Alternate low read never clears overflow; otherwise same as main pair.
// - High-byte access suspends that function until its low byte is accessed.
// - Control at 12: enables bits 7..5, zeros 4..2, edge bit 1, level bit 0.
// - Enables and level are read/write, reset to zero; enables gate interrupts.
// - Edge select 1 captures on rising edge, 0 on falling edge.
// - On next compare match the level bit drives the compare output pin.
// - Status at 13 is read-only flags; a set flag interrupts if enabled.
// - Capture flag sets per capture; clears by status read then capture low read.
// - Compare flag sets per match; clears by status read then compare low access.
// - Overflow flag clears by status access then main counter low read.
// - Valid capture edge latches the count into read-only capture at 14/15.
// - Compare register is checked against the count; a match sets compare flag.
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module frt_timer_core
  import frt_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_DEFAULT,
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Timer pins and interrupt
  input wire logic capture_input_pin_i,
  output logic compare_output_pin_o,
  output logic irq_o
);
  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  logic setup;
  logic done;
  logic rd_done;
  logic wr_done;
  assign setup = psel_i && !penable_i;
  assign done = psel_i && penable_i && pready_o;
  assign rd_done = done && !pwrite_i;
  assign wr_done = done && pwrite_i;

  // ==========================================================
  // State
  logic [15:0] count_r;
  logic [7:0] control_r;
  logic [7:0] flags_r;
  logic [7:0] armed_r;
  logic [7:0] buffer_r;
  logic buf_pend_r;
  logic [7:0] snap_lo_r;
  logic [15:0] capture_r;
  logic cap_hold_r;
  logic [15:0] compare_r;
  logic cmp_hold_r;
  logic cmp_chk_r;
  logic started_r;
  logic [$clog2(STARTUP_CYCLES+1)-1:0] start_cnt_r;
  logic tick;
  logic cap_rise;
  logic cap_fall;
  logic cap_event;
  logic cmp_hit;
  logic ovf_event;

  // ==========================================================
  // Prescaler and pin synchroniser
  frt_prescaler #(.DIV(PRESCALE_DIV)) u_presc
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(started_r),
    .tick_o(tick)
  );

  frt_edge_sync u_cap_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_input_pin_i),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );

  // ==========================================================
  // Start-up delay; counter frozen at its preset until it ends
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_cnt_r <= '0;
      started_r <= 1'b0;
    end
    else if (!started_r)
    begin
      start_cnt_r <= start_cnt_r + 1'b1;
      started_r <= (start_cnt_r == $bits(start_cnt_r)'(STARTUP_CYCLES - 1));
    end
  end

  // ==========================================================
  // Free-running counter; no write path exists
  // Single-edge design: the increment lands on the tick edge, standing in for the low phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_r <= COUNT_RESET;
    else if (tick)
      count_r <= count_r + 16'h0001;
  end

  assign ovf_event = tick && (count_r == COUNT_LAST);

  // ==========================================================
  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      control_r <= CONTROL_RESET;
    else if (wr_done && hit(paddr_i, IDX_CONTROL))
      control_r <= pwdata_i[7:0] & CONTROL_RW_MASK;
  end

  // ==========================================================
  // Input capture; a pending high-byte read blocks the transfer
  assign cap_event = control_r[EDGE_BIT] ? cap_rise : cap_fall;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_r <= '0;
    else if (cap_event && !cap_hold_r)
      capture_r <= count_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_hold_r <= 1'b0;
    else if (rd_done && hit(paddr_i, IDX_CAP_HI))
      cap_hold_r <= 1'b1;
    else if (rd_done && hit(paddr_i, IDX_CAP_LO))
      cap_hold_r <= 1'b0;
  end

  // ==========================================================
  // Output compare; checked the cycle after each count step
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_r <= '0;
    else if (wr_done && hit(paddr_i, IDX_CMP_HI))
      compare_r[15:8] <= pwdata_i[7:0];
    else if (wr_done && hit(paddr_i, IDX_CMP_LO))
      compare_r[7:0] <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_hold_r <= 1'b0;
    else if (wr_done && hit(paddr_i, IDX_CMP_HI))
      cmp_hold_r <= 1'b1;
    else if (done && hit(paddr_i, IDX_CMP_LO))
      cmp_hold_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cmp_chk_r <= 1'b0;
    else
      cmp_chk_r <= tick;
  end

  assign cmp_hit = cmp_chk_r && !cmp_hold_r && (count_r == compare_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      compare_output_pin_o <= 1'b0;
    else if (cmp_hit)
      compare_output_pin_o <= control_r[LEVEL_BIT];
  end

  // ==========================================================
  // Flags: set wins over clear; clear needs an armed bit
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  always_comb
  begin
    set_vec = '0;
    set_vec[CAP_BIT] = cap_event && !cap_hold_r;
    set_vec[CMP_BIT] = cmp_hit;
    set_vec[OVF_BIT] = ovf_event;
    clr_vec = '0;
    clr_vec[CAP_BIT] = rd_done && hit(paddr_i, IDX_CAP_LO);
    clr_vec[CMP_BIT] = done && hit(paddr_i, IDX_CMP_LO);
    clr_vec[OVF_BIT] = rd_done && hit(paddr_i, IDX_MAIN_LO);
    clr_vec = clr_vec & armed_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_r <= '0;
    else
      flags_r <= (flags_r & ~clr_vec) | set_vec;
  end

  // Arms from the value the status read returned, so later sets survive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      armed_r <= '0;
    else if (done && hit(paddr_i, IDX_FLAGS))
      armed_r <= pwrite_i ? flags_r : prdata_o[7:0];
    else
      armed_r <= armed_r & ~clr_vec;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(flags_r & control_r & {3'b111, 5'b00000});
  end

  // ==========================================================
  // Coherent counter read buffer, shared by both pairs
  logic cnt_hi_sel;
  logic cnt_lo_sel;
  assign cnt_hi_sel = hit(paddr_i, IDX_MAIN_HI) || hit(paddr_i, IDX_ALT_HI);
  assign cnt_lo_sel = hit(paddr_i, IDX_MAIN_LO) || hit(paddr_i, IDX_ALT_LO);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      buf_pend_r <= 1'b0;
      buffer_r <= '0;
    end
    else if (rd_done && cnt_hi_sel && !buf_pend_r)
    begin
      buf_pend_r <= 1'b1;
      buffer_r <= snap_lo_r;
    end
    else if (rd_done && cnt_lo_sel)
      buf_pend_r <= 1'b0;
  end

  // ==========================================================
  // APB read path; data and ready sampled in the setup cycle
  logic [7:0] rd_byte;
  logic mapped;
  always_comb
  begin
    rd_byte = '0;
    mapped = 1'b1;
    unique case (1'b1)
      hit(paddr_i, IDX_CONTROL): rd_byte = control_r;
      hit(paddr_i, IDX_FLAGS): rd_byte = flags_r;
      hit(paddr_i, IDX_CAP_HI): rd_byte = capture_r[15:8];
      hit(paddr_i, IDX_CAP_LO): rd_byte = capture_r[7:0];
      hit(paddr_i, IDX_CMP_HI): rd_byte = compare_r[15:8];
      hit(paddr_i, IDX_CMP_LO): rd_byte = compare_r[7:0];
      cnt_hi_sel: rd_byte = count_r[15:8];
      cnt_lo_sel: rd_byte = buf_pend_r ? buffer_r : count_r[7:0];
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      snap_lo_r <= '0;
    end
    else
    begin
      pready_o <= setup;
      if (setup)
      begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr_o <= !mapped;
        snap_lo_r <= count_r[7:0];
      end
      else if (done)
        pslverr_o <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_lo_setup;
    setup && !pwrite_i && cnt_lo_sel;
  endsequence

  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step on tick");
  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    tick |=> !tick [*3] ##1 tick)
    else $error("prescaler tick spacing wrong");
  a_reset_preset: assert property (@(posedge clk_i)
    rst_i |=> count_r == COUNT_RESET)
    else $error("counter not preset by reset");
  a_startup_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !started_r |=> $stable(count_r))
    else $error("counter moved before start-up");
  a_overflow_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_event |=> flags_r[OVF_BIT] && count_r == 16'h0000)
    else $error("overflow flag not set on wrap");
  a_low_live: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lo_setup and !buf_pend_r |=> prdata_o[7:0] == $past(count_r[7:0]))
    else $error("low read not live");
  a_low_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lo_setup and buf_pend_r |=> prdata_o[7:0] == $past(buffer_r))
    else $error("low read missed buffer");
  a_alt_keeps_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_done && hit(paddr_i, IDX_ALT_LO) && flags_r[OVF_BIT] |=> flags_r[OVF_BIT])
    else $error("alternate read cleared overflow");
  a_control_zeros: assert property (@(posedge clk_i) disable iff (rst_i)
    setup && !pwrite_i && hit(paddr_i, IDX_CONTROL) |=> prdata_o[4:2] == 3'b000)
    else $error("control reserved bits not zero");
  a_level_out: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_hit |=> compare_output_pin_o == $past(control_r[LEVEL_BIT]))
    else $error("compare pin did not take level");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == $past(|(flags_r[7:5] & control_r[7:5])))
    else $error("interrupt not gated by enables");
  a_unarmed_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_done && hit(paddr_i, IDX_MAIN_LO) && !armed_r[OVF_BIT] && flags_r[OVF_BIT]
    |=> flags_r[OVF_BIT])
    else $error("unarmed overflow flag cleared");
endmodule
`default_nettype wire

// [verification/frt_timer_core_tb.sv]
// Self-checking testbench for the free-running timer core
`timescale 1ns/10ps
`default_nettype none
module frt_timer_core_tb;
  import frt_pkg::*;
  // ==========================================================
  // Signals and instance
  // Long enough that a counter frozen after reset can be told apart
  localparam int STARTUP = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cap_pin = 1'b1;
  logic cmp_pin;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] c;
  logic [15:0] tgt;
  int n_errors = 0;
  int total_checks = 0;

  frt_timer_core #(.STARTUP_CYCLES(STARTUP), .ADDR_W(8)) i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .capture_input_pin_i(cap_pin),
    .compare_output_pin_o(cmp_pin),
    .irq_o(irq)
  );

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared tasks
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait: a missing pready ends the run instead of hanging
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      chk(pready, 1'b1);
      final_report();
    end
    else
    begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic pulse_pin(input logic lvl);
    cap_pin <= lvl;
    repeat (12) @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_overflow();
    rd(IDX_CONTROL);
    chk(rdat, 32'h0);
    rd(IDX_MAIN_HI);
    chk(rdat, 32'hFF);
    rd(IDX_MAIN_LO);
    rd(8'h00);
    chk(rerr, 1'b1);
    repeat (30) @(posedge clk_i);
    rd(IDX_FLAGS);
    chk(rdat[OVF_BIT], 1'b1);
    wr(IDX_CONTROL, 8'hFF);
    rd(IDX_CONTROL);
    chk(rdat, {24'h0, CONTROL_RW_MASK});
    wr(IDX_CONTROL, 8'h20);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wr(IDX_CONTROL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    rd(IDX_ALT_LO);
    rd(IDX_FLAGS);
    chk(rdat[OVF_BIT], 1'b1);
    rd(IDX_MAIN_LO);
    rd(IDX_FLAGS);
    chk(rdat[OVF_BIT], 1'b0);
    $display("test reset_overflow done");
  endtask

  // Reads are spaced in whole prescaler periods so deltas are exact
  task automatic t_rate_buffer();
    rd(IDX_ALT_LO);
    a = rdat[7:0];
    repeat (37) @(posedge clk_i);
    rd(IDX_ALT_HI);
    repeat (37) @(posedge clk_i);
    rd(IDX_ALT_HI);
    rd(IDX_ALT_LO);
    b = a + 8'h0A;
    chk(rdat[7:0], b);
    repeat (2) @(posedge clk_i);
    rd(IDX_ALT_LO);
    b = a + 8'h16;
    chk(rdat[7:0], b);
    rd(IDX_ALT_LO);
    a = rdat[7:0];
    wr(IDX_MAIN_HI, 8'h00);
    wr(IDX_MAIN_LO, 8'h00);
    wr(IDX_ALT_LO, 8'h00);
    repeat (4) @(posedge clk_i);
    rd(IDX_ALT_LO);
    b = a + 8'h04;
    chk(rdat[7:0], b);
    $display("test rate_buffer done");
  endtask

  task automatic t_capture();
    rd(IDX_ALT_LO);
    a = rdat[7:0];
    pulse_pin(1'b0);
    rd(IDX_CAP_LO);
    c = rdat[7:0];
    chk((c - a) <= 8'h03, 1'b1);
    rd(IDX_FLAGS);
    chk(rdat[CAP_BIT], 1'b1);
    rd(IDX_CAP_LO);
    rd(IDX_FLAGS);
    chk(rdat[CAP_BIT], 1'b0);
    pulse_pin(1'b1);
    wr(IDX_CONTROL, 8'h82);
    pulse_pin(1'b0);
    chk(irq, 1'b0);
    pulse_pin(1'b1);
    chk(irq, 1'b1);
    rd(IDX_FLAGS);
    rd(IDX_CAP_LO);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    rd(IDX_CAP_HI);
    pulse_pin(1'b0);
    pulse_pin(1'b1);
    chk(irq, 1'b0);
    rd(IDX_CAP_LO);
    pulse_pin(1'b0);
    pulse_pin(1'b1);
    chk(irq, 1'b1);
    rd(IDX_FLAGS);
    rd(IDX_CAP_LO);
    $display("test capture done");
  endtask

  task automatic t_compare();
    int n;
    wr(IDX_CONTROL, 8'h01);
    rd(IDX_ALT_HI);
    tgt[15:8] = rdat[7:0];
    rd(IDX_ALT_LO);
    tgt[7:0] = rdat[7:0];
    tgt = tgt + 16'h001E;
    wr(IDX_CMP_HI, tgt[15:8]);
    wr(IDX_CMP_LO, tgt[7:0]);
    chk(cmp_pin, 1'b0);
    n = 0;
    while (cmp_pin !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(cmp_pin, 1'b1);
    rd(IDX_FLAGS);
    chk(rdat[CMP_BIT], 1'b1);
    wr(IDX_CMP_LO, tgt[7:0]);
    rd(IDX_FLAGS);
    chk(rdat[CMP_BIT], 1'b0);
    $display("test compare done");
  endtask

  // Mid-run reset: counter preset and frozen through the start-up delay
  task automatic t_restart();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_MAIN_LO);
    chk(rdat, 32'h0000_00FC);
    repeat (8) @(posedge clk_i);
    rd(IDX_MAIN_LO);
    chk(rdat, 32'h0000_00FC);
    rd(IDX_CONTROL);
    chk(rdat, 32'h0000_0000);
    chk(irq, 1'b0);
    chk(cmp_pin, 1'b0);
    $display("test restart done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_overflow();
    t_rate_buffer();
    t_capture();
    t_compare();
    t_restart();
    final_report();
  end
endmodule
`default_nettype wire
